// ===== logic/pdc_channel.sv
// DMA channel control: configuration byte, chaining, start and stop of transfers.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module pdc_channel #(
    parameter int CW = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic desc_req_o,
    output logic [31:0] desc_addr_o,
    input wire logic desc_valid_i,
    input wire logic desc_err_i,
    input wire logic [CW-1:0] desc_count_i,
    input wire logic [31:0] desc_next_i,
    output logic word_req_o,
    output logic word_dir_o,
    output logic [4:0] word_len_o,
    input wire logic word_done_i,
    input wire logic word_err_i,
    output logic irq_o
);

    typedef struct packed {
        pdc_pkg::pdc_state_type st;
        logic channel_reset_bit;
        logic dir;
        logic [1:0] size;
        logic run;
        logic chain;
        logic [CW-1:0] count;
        logic [31:0] chaddr;
        logic desc_req;
        logic start;
        logic [31:0] rdata;
    } pdc_regs_type;

    pdc_regs_type q, d;

    logic wr_cfg, wr_cnt, wr_chaddr, wr_stat, wr_mask;
    logic eng_rst_n, eng_req, eng_halted, eng_err;
    logic [pdc_pkg::NUM_EV-1:0] ev, irq_stat, irq_mask;
    logic [7:0] cfg_byte;

    assign wr_cfg = reg_wr_i && reg_addr_i == pdc_pkg::CFG_OFS;
    assign wr_cnt = reg_wr_i && reg_addr_i == pdc_pkg::COUNT_OFS;
    assign wr_chaddr = reg_wr_i && reg_addr_i == pdc_pkg::CHADDR_OFS;
    assign wr_stat = reg_wr_i && reg_addr_i == pdc_pkg::IRQ_STAT_OFS;
    assign wr_mask = reg_wr_i && reg_addr_i == pdc_pkg::IRQ_MASK_OFS;

    // The engine is held in reset together with the channel.
    assign eng_rst_n = rst_n_i && !q.channel_reset_bit;

    always_comb begin
        cfg_byte = '0;
        cfg_byte[pdc_pkg::CHAIN_BIT] = q.chain;
        cfg_byte[pdc_pkg::RUN_BIT] = q.run;
        cfg_byte[pdc_pkg::SIZE_MSB:pdc_pkg::SIZE_LSB] = q.size;
        cfg_byte[pdc_pkg::DIR_BIT] = q.dir;
        cfg_byte[pdc_pkg::CHANNEL_RESET_BIT_BIT] = q.channel_reset_bit;
    end

    always_comb begin
        d = q;
        d.start = 1'b0;
        d.rdata = '0;
        ev = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                pdc_pkg::CFG_OFS: d.rdata = {24'h000000, cfg_byte};
                pdc_pkg::COUNT_OFS: d.rdata = 32'(q.count);
                pdc_pkg::CHADDR_OFS: d.rdata = q.chaddr;
                pdc_pkg::IRQ_STAT_OFS: d.rdata = 32'(irq_stat);
                pdc_pkg::IRQ_MASK_OFS: d.rdata = 32'(irq_mask);
                default: d.rdata = '0;
            endcase
        end
        if (word_done_i && eng_req && q.count != '0) begin
            d.count = q.count - CW'(1);
        end
        case (q.st)
            pdc_pkg::ST_IDLE: begin
                if (q.run) begin
                    if (q.count != '0) begin
                        d.st = pdc_pkg::ST_XFER;
                    end else if (q.chain) begin
                        d.st = pdc_pkg::ST_FETCH;
                    end else begin
                        d.run = 1'b0;
                    end
                end
            end
            pdc_pkg::ST_FETCH: begin
                d.desc_req = 1'b1;
                if (desc_err_i) begin
                    d.desc_req = 1'b0;
                    d.run = 1'b0;
                    ev[pdc_pkg::EV_ERR] = 1'b1;
                    d.st = pdc_pkg::ST_IDLE;
                end else if (desc_valid_i) begin
                    d.desc_req = 1'b0;
                    d.count = desc_count_i;
                    d.chaddr = desc_next_i;
                    d.chain = desc_next_i != '0;
                    ev[pdc_pkg::EV_CHAIN] = 1'b1;
                    d.st = pdc_pkg::ST_XFER;
                end else if (!q.run) begin
                    d.desc_req = 1'b0;
                    d.st = pdc_pkg::ST_IDLE;
                end
            end
            pdc_pkg::ST_XFER: begin
                if (!q.run) begin
                    d.st = (eng_req || q.start) ? pdc_pkg::ST_HALT : pdc_pkg::ST_IDLE;
                end else if (eng_err) begin
                    d.run = 1'b0;
                    ev[pdc_pkg::EV_ERR] = 1'b1;
                    d.st = pdc_pkg::ST_IDLE;
                end else if (!eng_req && !q.start) begin
                    if (q.count != '0) begin
                        d.start = 1'b1;
                    end else if (q.chain) begin
                        d.st = pdc_pkg::ST_FETCH;
                    end else begin
                        d.run = 1'b0;
                        ev[pdc_pkg::EV_DONE] = 1'b1;
                        d.st = pdc_pkg::ST_IDLE;
                    end
                end
            end
            pdc_pkg::ST_HALT: begin
                if (eng_err) begin
                    ev[pdc_pkg::EV_ERR] = 1'b1;
                end
                if (!eng_req && !q.start) begin
                    d.st = pdc_pkg::ST_IDLE;
                end
            end
            default: d.st = pdc_pkg::ST_IDLE;
        endcase
        if (wr_cfg) begin
            d.channel_reset_bit = reg_wdata_i[pdc_pkg::CHANNEL_RESET_BIT_BIT];
            d.dir = reg_wdata_i[pdc_pkg::DIR_BIT];
            d.size = reg_wdata_i[pdc_pkg::SIZE_MSB:pdc_pkg::SIZE_LSB];
            if (!reg_wdata_i[pdc_pkg::RUN_BIT]) begin
                d.run = 1'b0;
            end else if (q.count != '0 || q.chain) begin
                d.run = 1'b1;
            end
        end
        if (wr_cnt) begin
            d.count = reg_wdata_i[CW-1:0];
        end
        if (wr_chaddr) begin
            d.chaddr = reg_wdata_i;
            d.chain = reg_wdata_i != '0;
            if (reg_wdata_i != '0) begin
                d.run = 1'b1;
            end
        end
        if (q.channel_reset_bit) begin
            d.st = pdc_pkg::ST_IDLE;
            d.run = pdc_pkg::RUN_RST;
            d.chain = pdc_pkg::CHAIN_RST;
            d.count = '0;
            d.chaddr = '0;
            d.desc_req = 1'b0;
            d.start = 1'b0;
            ev = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.st <= pdc_pkg::ST_IDLE;
            q.channel_reset_bit <= pdc_pkg::CHANNEL_RESET_BIT_RST;
            q.dir <= pdc_pkg::DIR_RST;
            q.size <= pdc_pkg::SIZE_RST;
        end else begin
            q <= d;
        end
    end

    pdc_word_engine #(
        .CW(CW)
    ) u_engine (
        .clk_i(clk_i),
        .rst_n_i(eng_rst_n),
        .start_i(q.start),
        .stop_i(!q.run),
        .size_i(q.size),
        .dir_i(q.dir),
        .remaining_i(q.count),
        .word_done_i(word_done_i),
        .word_err_i(word_err_i),
        .req_o(eng_req),
        .dir_o(word_dir_o),
        .len_o(word_len_o),
        .halted_o(eng_halted),
        .err_o(eng_err)
    );

    pdc_irq_ctrl #(
        .N(pdc_pkg::NUM_EV)
    ) u_irq (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .event_i(ev),
        .stat_wr_i(wr_stat),
        .mask_wr_i(wr_mask),
        .wdata_i(reg_wdata_i[pdc_pkg::NUM_EV-1:0]),
        .stat_o(irq_stat),
        .mask_o(irq_mask),
        .irq_o(irq_o)
    );

    assign word_req_o = eng_req;
    assign reg_rdata_o = q.rdata;
    assign desc_req_o = q.desc_req;
    assign desc_addr_o = q.chaddr;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_stop_in_burst;
        !q.run && word_req_o;
    endsequence

    sequence s_burst_cut;
        ##[1:8] !word_req_o;
    endsequence

    property p_chain_set;
        wr_chaddr && reg_wdata_i != '0 && !q.channel_reset_bit |=> q.chain;
    endproperty
    a_chain_set: assert property (p_chain_set) else $error("chain flag not set");

    property p_chain_clr;
        wr_chaddr && reg_wdata_i == '0 && !q.channel_reset_bit |=> !q.chain;
    endproperty
    a_chain_clr: assert property (p_chain_clr) else $error("chain flag not cleared");

    property p_channel_reset_bit_hold;
        q.channel_reset_bit |=> !q.chain && !q.run && q.st == pdc_pkg::ST_IDLE && !word_req_o;
    endproperty
    a_channel_reset_bit_hold: assert property (p_channel_reset_bit_hold) else $error("channel not held in reset");

    property p_start_ok;
        wr_cfg && reg_wdata_i[pdc_pkg::RUN_BIT] && q.count != '0 && !q.channel_reset_bit |=> q.run;
    endproperty
    a_start_ok: assert property (p_start_ok) else $error("start write lost");

    property p_start_refused;
        wr_cfg && reg_wdata_i[pdc_pkg::RUN_BIT] && q.count == '0 && !q.chain && !q.run
            |=> !q.run;
    endproperty
    a_start_refused: assert property (p_start_refused) else $error("empty start taken");

    property p_auto_start;
        wr_chaddr && reg_wdata_i != '0 && !q.channel_reset_bit |=> q.run;
    endproperty
    a_auto_start: assert property (p_auto_start) else $error("no automatic start");

    property p_halt;
        s_stop_in_burst |-> s_burst_cut;
    endproperty
    a_halt: assert property (p_halt) else $error("stopped burst not cut off");

    property p_halt_done;
        eng_halted |-> q.st == pdc_pkg::ST_HALT;
    endproperty
    a_halt_done: assert property (p_halt_done) else $error("halt outside stop state");

    property p_done;
        q.st == pdc_pkg::ST_XFER && q.run && !eng_req && !q.start && q.count == '0
            && !q.chain && !q.channel_reset_bit && !wr_cfg && !wr_chaddr |=> !q.run ##1 irq_stat[pdc_pkg::EV_DONE];
    endproperty
    a_done: assert property (p_done) else $error("completion did not stop channel");

    property p_fetch;
        q.st == pdc_pkg::ST_XFER && q.run && !eng_req && !q.start && q.count == '0
            && q.chain && !q.channel_reset_bit && !wr_cfg |=> q.st == pdc_pkg::ST_FETCH ##1 desc_req_o;
    endproperty
    a_fetch: assert property (p_fetch) else $error("chained descriptor not fetched");

    property p_len;
        $rose(word_req_o) |-> word_len_o == pdc_pkg::LEN_ONE
            || ($past(q.size) == pdc_pkg::SIZE_BURST && word_len_o <= pdc_pkg::BURST_MAX);
    endproperty
    a_len: assert property (p_len) else $error("burst length wrong");

    property p_dir;
        $rose(word_req_o) |-> word_dir_o == $past(q.dir);
    endproperty
    a_dir: assert property (p_dir) else $error("direction not taken");

    property p_reserved;
        reg_rd_i && reg_addr_i == pdc_pkg::CFG_OFS |=> reg_rdata_o[5:4] == 2'h0
            && reg_rdata_o[31:8] == 24'h000000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

endmodule // pdc_channel

// ===== logic/pdc_irq_ctrl.sv
// Sticky interrupt status with write-one-to-clear, mask and one level output.
`timescale 1ns/100ps
module pdc_irq_ctrl #(
    parameter int N = 3
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [N-1:0] event_i,
    input wire logic stat_wr_i,
    input wire logic mask_wr_i,
    input wire logic [N-1:0] wdata_i,
    output logic [N-1:0] stat_o,
    output logic [N-1:0] mask_o,
    output logic irq_o
);

    typedef struct packed {
        logic [N-1:0] stat;
        logic [N-1:0] mask;
        logic irq;
    } pdc_irq_regs_type;

    pdc_irq_regs_type q, d;

    // A new event wins over a clear written in the same cycle.
    always_comb begin
        d = q;
        if (stat_wr_i) begin
            d.stat = q.stat & ~wdata_i;
        end
        d.stat = d.stat | event_i;
        if (mask_wr_i) begin
            d.mask = wdata_i;
        end
        d.irq = |(d.stat & d.mask);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign stat_o = q.stat;
    assign mask_o = q.mask;
    assign irq_o = q.irq;

endmodule // pdc_irq_ctrl

// ===== logic/pdc_word_engine.sv
// Word transfer engine: issues one single or burst request and counts its words.
`timescale 1ns/100ps
module pdc_word_engine #(
    parameter int CW = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic [1:0] size_i,
    input wire logic dir_i,
    input wire logic [CW-1:0] remaining_i,
    input wire logic word_done_i,
    input wire logic word_err_i,
    output logic req_o,
    output logic dir_o,
    output logic [4:0] len_o,
    output logic halted_o,
    output logic err_o
);

    typedef struct packed {
        pdc_pkg::pdc_eng_state_type st;
        logic req;
        logic dir;
        logic [4:0] len;
        logic [4:0] left;
        logic [2:0] cnt;
        logic halted;
        logic err;
    } pdc_eng_regs_type;

    pdc_eng_regs_type q, d;
    logic [4:0] first_len;

    // Reserved size codes fall back to single words.
    always_comb begin
        first_len = pdc_pkg::LEN_ONE;
        if (size_i == pdc_pkg::SIZE_BURST) begin
            if (remaining_i >= CW'(pdc_pkg::BURST_MAX)) begin
                first_len = pdc_pkg::BURST_MAX;
            end else begin
                first_len = remaining_i[4:0];
            end
        end
    end

    always_comb begin
        d = q;
        d.halted = 1'b0;
        d.err = 1'b0;
        case (q.st)
            pdc_pkg::EN_IDLE: begin
                if (start_i) begin
                    d.req = 1'b1;
                    d.dir = dir_i;
                    d.len = first_len;
                    d.left = first_len;
                    d.st = pdc_pkg::EN_BUSY;
                end
            end
            pdc_pkg::EN_BUSY, pdc_pkg::EN_HALT: begin
                if (word_err_i) begin
                    d.req = 1'b0;
                    d.err = 1'b1;
                    d.st = pdc_pkg::EN_IDLE;
                end else if (word_done_i && q.left == pdc_pkg::LEN_ONE) begin
                    d.left = '0;
                    d.req = 1'b0;
                    d.halted = (q.st == pdc_pkg::EN_HALT);
                    d.st = pdc_pkg::EN_IDLE;
                end else begin
                    if (word_done_i) begin
                        d.left = q.left - 5'h01;
                    end
                    if (q.st == pdc_pkg::EN_BUSY && stop_i) begin
                        d.cnt = pdc_pkg::HALT_CYCLES;
                        d.st = pdc_pkg::EN_HALT;
                    end else if (q.st == pdc_pkg::EN_HALT) begin
                        if (q.cnt == 3'h0) begin
                            d.req = 1'b0;
                            d.halted = 1'b1;
                            d.st = pdc_pkg::EN_IDLE;
                        end else begin
                            d.cnt = q.cnt - 3'h1;
                        end
                    end
                end
            end
            default: begin
                d.req = 1'b0;
                d.st = pdc_pkg::EN_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign req_o = q.req;
    assign dir_o = q.dir;
    assign len_o = q.len;
    assign halted_o = q.halted;
    assign err_o = q.err;

endmodule // pdc_word_engine

// ===== pkg/pdc_pkg.sv
// Constants and types shared by the DMA channel control logic.
package pdc_pkg;

    // Register byte offsets on the plain register port.
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] COUNT_OFS = 8'h04;
    localparam logic [7:0] CHADDR_OFS = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

    // Field positions in the channel configuration register.
    localparam int CHAIN_BIT = 7;
    localparam int RUN_BIT = 6;
    localparam int SIZE_LSB = 2;
    localparam int SIZE_MSB = 3;
    localparam int DIR_BIT = 1;
    localparam int CHANNEL_RESET_BIT_BIT = 0;

    // Values after reset.
    localparam logic CHANNEL_RESET_BIT_RST = 1'b1;
    localparam logic RUN_RST = 1'b0;
    localparam logic CHAIN_RST = 1'b0;
    localparam logic DIR_RST = 1'b0;
    localparam logic [1:0] SIZE_RST = 2'h0;

    // Transfer size codes.
    localparam logic [1:0] SIZE_SINGLE = 2'h0;
    localparam logic [1:0] SIZE_BURST = 2'h1;
    localparam logic [4:0] BURST_MAX = 5'h10;
    localparam logic [4:0] LEN_ONE = 5'h01;

    // Countdown for a stopped burst: it may still run HALT_CYCLES + 1 cycles in the halt state before it is cut off.
    localparam logic [2:0] HALT_CYCLES = 3'h4;

    // Interrupt event bits.
    localparam int EV_DONE = 0;
    localparam int EV_CHAIN = 1;
    localparam int EV_ERR = 2;
    localparam int NUM_EV = 3;

    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_XFER, ST_HALT} pdc_state_type;
    typedef enum logic [1:0] {EN_IDLE, EN_BUSY, EN_HALT} pdc_eng_state_type;

endpackage

// ===== verif/pdc_channel_tb_top.sv
// Self-checking testbench of the DMA channel control block.
`timescale 1ns/100ps
module pdc_channel_tb_top;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h00000000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic desc_req_o, desc_valid_i, desc_err_i, word_req_o, word_dir_o, word_done_i;
    logic word_err_i, irq_o, err_i = 1'b0, req_prev = 1'b0, exp_dir = 1'b0;
    logic [31:0] desc_addr_o, desc_next_i, nxt_addr = 32'h00000000;
    logic [15:0] desc_count_i, nxt_count = 16'h0000;
    logic [4:0] word_len_o;
    logic [3:0] gap = 4'h0;
    logic [4:0] exp_len_q[$];
    int fail_count = 0;
    int cmp_count = 0;
    int words_seen = 0;

    always #4 clk_i = ~clk_i;

    pdc_channel #(.CW(16)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .desc_req_o(desc_req_o), .desc_addr_o(desc_addr_o),
        .desc_valid_i(desc_valid_i), .desc_err_i(desc_err_i), .desc_count_i(desc_count_i),
        .desc_next_i(desc_next_i), .word_req_o(word_req_o), .word_dir_o(word_dir_o),
        .word_len_o(word_len_o), .word_done_i(word_done_i), .word_err_i(word_err_i),
        .irq_o(irq_o));

    pdc_far_model far_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .desc_req_i(desc_req_o),
        .word_req_i(word_req_o), .word_len_i(word_len_o), .gap_i(gap), .err_i(err_i),
        .nxt_count_i(nxt_count), .nxt_addr_i(nxt_addr), .desc_valid_o(desc_valid_i),
        .desc_err_o(desc_err_i), .desc_count_o(desc_count_i), .desc_next_o(desc_next_i),
        .word_done_o(word_done_i), .word_err_o(word_err_i));

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_req(input logic [5:0] got, input logic [5:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t request dir/len %h expected %h", $time, got, exp);
        end
    endtask

    // Each new word request is checked against the planned direction and length.
    always @(posedge clk_i) begin
        req_prev <= word_req_o;
        if (word_req_o === 1'b1 && word_done_i === 1'b1) begin
            words_seen <= words_seen + 1;
        end
        if (word_req_o === 1'b1 && req_prev !== 1'b1) begin
            if (exp_len_q.size() == 0) begin
                chk_req({word_dir_o, word_len_o}, 6'h00);
            end else begin
                chk_req({word_dir_o, word_len_o}, {exp_dir, exp_len_q.pop_front()});
            end
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk_val(d & m, e);
    endtask

    function automatic logic [31:0] cfg(input int run, input int sz, input int dir);
        return (run << pdc_pkg::RUN_BIT) | (sz << pdc_pkg::SIZE_LSB) | (dir << pdc_pkg::DIR_BIT);
    endfunction

    task automatic wait_idle();
        logic [31:0] d;
        for (int i = 0; i < 300; i++) begin
            rd(pdc_pkg::CFG_OFS, d);
            if (d[pdc_pkg::RUN_BIT] === 1'b0) return;
        end
        fail_count++;
        complete_run();
    endtask

    task automatic wait_sig(input int which, input logic lvl);
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_i);
            #1;
            if ((which == 0 ? word_req_o : desc_req_o) === lvl) return;
        end
        fail_count++;
        complete_run();
    endtask

    task automatic plan(input int cnt, input int sz, input int dir);
        int l;
        exp_dir = dir[0];
        while (cnt > 0) begin
            l = (sz == 1) ? ((cnt > 16) ? 16 : cnt) : 1;
            exp_len_q.push_back(l[4:0]);
            cnt -= l;
        end
    endtask

    task automatic run_xfer(input int cnt, input int sz, input int dir);
        wr(pdc_pkg::IRQ_STAT_OFS, 32'h00000007);
        wr(pdc_pkg::COUNT_OFS, cnt);
        plan(cnt, sz, dir);
        words_seen = 0;
        wr(pdc_pkg::CFG_OFS, cfg(1, sz, dir));
        wait_idle();
        chk_val(words_seen, cnt);
        chk_val(exp_len_q.size(), 0);
        chk_reg(pdc_pkg::CFG_OFS, 32'hFFFFFFFF, cfg(0, sz, dir));
        chk_reg(pdc_pkg::IRQ_STAT_OFS, 32'h00000001, 32'h00000001);
    endtask

    initial begin
        void'($urandom(32'h4E95));
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        chk_reg(pdc_pkg::CFG_OFS, 32'hFFFFFFFF, 32'h00000001);
        wr(pdc_pkg::COUNT_OFS, 32'h00000005);
        wr(pdc_pkg::CFG_OFS, 32'h00000000);
        chk_reg(pdc_pkg::COUNT_OFS, 32'h0000FFFF, 32'h00000000);
        wr(pdc_pkg::CFG_OFS, 32'h00000076);
        chk_reg(pdc_pkg::CFG_OFS, 32'hFFFFFFFF, 32'h00000006);
        chk_reg(8'h40, 32'hFFFFFFFF, 32'h00000000);
        for (int s = 0; s < 4; s++) begin
            for (int d = 0; d < 2; d++) begin
                run_xfer($urandom_range(1, 40), s, d);
            end
        end
        // A chain address load fetches, follows a nonzero fetched link once, stops on zero.
        gap = 4'h8;
        nxt_count = 16'h0005;
        nxt_addr = 32'h00003000;
        wr(pdc_pkg::CFG_OFS, cfg(0, 1, 1));
        plan(5, 1, 1);
        plan(5, 1, 1);
        words_seen = 0;
        wr(pdc_pkg::CHADDR_OFS, 32'h00001000);
        chk_reg(pdc_pkg::CFG_OFS, 32'h000000C0, 32'h000000C0);
        wait_sig(1, 1'b1);
        chk_val(desc_addr_o, 32'h00001000);
        wait_sig(1, 1'b0);
        nxt_addr = 32'h00000000;
        chk_reg(pdc_pkg::CFG_OFS, 32'h00000080, 32'h00000080);
        wait_sig(1, 1'b1);
        chk_val(desc_addr_o, 32'h00003000);
        wait_idle();
        chk_val(words_seen, 10);
        chk_reg(pdc_pkg::CFG_OFS, 32'h000000C0, 32'h00000000);
        chk_reg(pdc_pkg::IRQ_STAT_OFS, 32'h00000002, 32'h00000002);
        // Channel reset while a fetch is pending clears the chain flag.
        gap = 4'hF;
        wr(pdc_pkg::CHADDR_OFS, 32'h00002000);
        wr(pdc_pkg::CFG_OFS, 32'h00000001);
        chk_reg(pdc_pkg::CFG_OFS, 32'h000000C1, 32'h00000001);
        wr(pdc_pkg::CFG_OFS, cfg(0, 1, 0));
        // Clearing the running bit in mid-burst halts the burst shortly.
        gap = 4'h6;
        wr(pdc_pkg::COUNT_OFS, 32'h00000010);
        plan(16, 1, 0);
        wr(pdc_pkg::CFG_OFS, cfg(1, 1, 0));
        wait_sig(0, 1'b1);
        wr(pdc_pkg::CFG_OFS, cfg(0, 1, 0));
        wait_sig(0, 1'b0);
        repeat (30) @(posedge clk_i);
        chk_reg(pdc_pkg::CFG_OFS, 32'h00000040, 32'h00000000);
        chk_val(exp_len_q.size(), 0);
        // An error ends the run, sets the sticky status and drives the interrupt when unmasked.
        gap = 4'h0;
        err_i = 1'b1;
        wr(pdc_pkg::IRQ_STAT_OFS, 32'h00000007);
        wr(pdc_pkg::COUNT_OFS, 32'h00000003);
        plan(1, 0, 1);
        wr(pdc_pkg::CFG_OFS, cfg(1, 0, 1));
        wait_idle();
        chk_reg(pdc_pkg::IRQ_STAT_OFS, 32'h00000004, 32'h00000004);
        chk_val(irq_o, 1'b0);
        wr(pdc_pkg::IRQ_MASK_OFS, 32'h00000004);
        repeat (2) @(posedge clk_i);
        chk_val(irq_o, 1'b1);
        wr(pdc_pkg::IRQ_STAT_OFS, 32'h00000004);
        repeat (2) @(posedge clk_i);
        chk_val(irq_o, 1'b0);
        complete_run();
    end
endmodule // pdc_channel_tb_top

// ===== verif/pdc_far_model.sv
// Far-side model: descriptor memory and word mover answering the channel requests.
`timescale 1ns/100ps
module pdc_far_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic desc_req_i,
    input wire logic word_req_i,
    input wire logic [4:0] word_len_i,
    input wire logic [3:0] gap_i,
    input wire logic err_i,
    input wire logic [15:0] nxt_count_i,
    input wire logic [31:0] nxt_addr_i,
    output logic desc_valid_o,
    output logic desc_err_o,
    output logic [15:0] desc_count_o,
    output logic [31:0] desc_next_o,
    output logic word_done_o,
    output logic word_err_o
);
    logic [3:0] wait_q;
    logic [4:0] sent_q;

    // Descriptor lines outside a valid cycle carry the inverse of their last value.
    always @(posedge clk_i) begin
        desc_valid_o <= 1'b0;
        desc_err_o <= 1'b0;
        word_done_o <= 1'b0;
        word_err_o <= 1'b0;
        desc_count_o <= ~desc_count_o;
        desc_next_o <= ~desc_next_o;
        if (!rst_n_i) begin
            wait_q <= 4'h0;
            sent_q <= 5'h00;
            desc_count_o <= 16'h0000;
            desc_next_o <= 32'h00000000;
        end else begin
            if (desc_req_i && !desc_valid_o) begin
                if (wait_q >= gap_i) begin
                    desc_valid_o <= 1'b1;
                    desc_count_o <= nxt_count_i;
                    desc_next_o <= nxt_addr_i;
                    wait_q <= 4'h0;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end
            if (!word_req_i) begin
                sent_q <= 5'h00;
            end else if (sent_q < word_len_i && !word_done_o && !word_err_o) begin
                if (wait_q >= gap_i) begin
                    word_err_o <= err_i;
                    word_done_o <= !err_i;
                    sent_q <= sent_q + 5'h01;
                    wait_q <= 4'h0;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end
        end
    end
endmodule // pdc_far_model
